// File: wst_pkg.sv
// Package for the weld sequence timing block: mode codes, limits and
// timing constants shared by the sequencer and its helpers.
// Assumes a 25 MHz system clock and a 60 Hz power line.
package wst_pkg;
    // Clock and line rates; one line cycle is the unit of every interval.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned LINE_HZ = 60;
    localparam int unsigned LINE_DIV = CLK_HZ / LINE_HZ;
    localparam int unsigned TICK_W = 20;

    // Seam selection codes of the extended settings menu.
    localparam logic [7:0] SEAM_SPOT = 8'h00;
    localparam logic [7:0] SEAM_CONT = 8'h01;
    localparam logic [7:0] SEAM_NONBEAT = 8'h06;

    // Beat initiation code for beat during squeeze and weld.
    localparam logic [7:0] BEAT_SQZ_WELD = 8'h02;

    // Limits and encodings of schedule values.
    localparam int unsigned CNT_W = 7;
    localparam logic [6:0] HEAT_MAX = 7'h63;
    localparam logic [6:0] MANUAL_MARK = 7'h63;
    localparam logic [7:0] SQZ_DLY_OFF = 8'h00;
    localparam logic [6:0] CNT_RESET = 7'h00;

    // Squeeze indicator dimming: lit for DIM_ON of every 8 clocks of the 3-bit dim count.
    localparam logic [2:0] DIM_ON = 3'h6;

    // Sequencer states, Gray coded along spot squeeze, weld, cool, hold.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SQZ_DLY = 3'b001,
        ST_SQUEEZE = 3'b011,
        ST_WELD = 3'b010,
        ST_COOL = 3'b110,
        ST_HOLD = 3'b111,
        ST_OFF = 3'b101,
        ST_MANUAL = 3'b100
    } wst_state_e;
endpackage : wst_pkg

// File: wst_sync.sv
// Three-stage input synchroniser for operator switch pins.
// Assumes the pin may change at any time relative to i_clk.
`timescale 1ns/10ps
`default_nettype none
module wst_sync
    import wst_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pin side
    input wire logic i_pin,
    // Clock side
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_level <= 1'b0;
        end else if (s2_q == s3_q) begin
            o_level <= s3_q;
        end
    end
endmodule : wst_sync
`default_nettype wire

// File: wst_line_tick.sv
// Divider that turns the system clock into one pulse per line cycle.
// Assumes the divide ratio fits in TICK_W bits.
`timescale 1ns/10ps
`default_nettype none
module wst_line_tick
    import wst_pkg::*;
#(
    parameter int unsigned P_DIV = LINE_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Line cycle enable
    output logic o_tick
);
    localparam logic [TICK_W-1:0] LAST = TICK_W'(P_DIV - 1);
    logic [TICK_W-1:0] div_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_q <= '0;
            o_tick <= 1'b0;
        end else if (div_q == LAST) begin
            div_q <= '0;
            o_tick <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule : wst_line_tick
`default_nettype wire

// File: wst_sequencer.sv
// Weld sequence timer: squeeze delay, squeeze, weld, cool, hold and off
// intervals for spot, seam, non-beat seam and brazing operation.
// Assumes schedule inputs are steady and show the next schedule from the
// edge after o_next_sched; switch inputs come straight from pins.
`timescale 1ns/10ps
`default_nettype none
module wst_sequencer
    import wst_pkg::*;
#(
    parameter int unsigned P_LINE_DIV = LINE_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Operator switches (pins)
    input wire logic i_first_stage,
    input wire logic i_second_stage,
    // Extended settings
    input wire logic [7:0] i_seam_sel,
    input wire logic [7:0] i_beat_init,
    input wire logic [7:0] i_sqz_delay,
    // Current schedule
    input wire logic [6:0] i_squeeze,
    input wire logic [6:0] i_heat,
    input wire logic [6:0] i_percent,
    input wire logic [6:0] i_hold,
    input wire logic [6:0] i_off,
    input wire logic [6:0] i_impulses,
    input wire logic [6:0] i_cool,
    input wire logic [6:0] i_percent2,
    input wire logic i_chained,
    input wire logic i_repeat,
    // Firing and valve
    output logic o_fire,
    output logic [6:0] o_fire_percent,
    output logic o_valve,
    // Indicators and schedule control
    output logic o_sqz_led,
    output logic o_sqz_dim,
    output logic o_next_sched,
    output logic o_busy
);
    wst_state_e state_q;
    wst_state_e state_d;
    logic first_lvl;
    logic second_lvl;
    logic tick;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] imp_q;
    logic [2:0] dim_q;
    logic seam_q;
    logic nonbeat_q;
    logic beat_q;
    logic manual_q;
    logic sqz_done_q;
    logic rep_q;
    logic chain_d;
    logic rep_d;
    logic [6:0] target;
    logic [6:0] heat_lim;
    logic done;
    logic init;
    logic fire_d;

    wst_sync u_sync_first (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_first_stage),
        .o_level(first_lvl)
    );

    wst_sync u_sync_second (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_second_stage),
        .o_level(second_lvl)
    );

    wst_line_tick #(
        .P_DIV(P_LINE_DIV)
    ) u_tick (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_tick(tick)
    );

    // The second stage is the initiation contact in sequenced modes.
    assign init = second_lvl;

    // A single spot weld interval never heats longer than the ceiling.
    assign heat_lim = (i_heat > HEAT_MAX) ? HEAT_MAX : i_heat;

    // Programmed length of the interval the current state is timing.
    always_comb begin
        unique case (state_q)
            ST_SQZ_DLY: target = i_sqz_delay[6:0];
            ST_SQUEEZE: target = i_squeeze;
            ST_WELD: target = heat_lim;
            ST_COOL: target = i_cool;
            ST_HOLD: target = i_hold;
            ST_OFF: target = i_off;
            ST_IDLE: target = CNT_RESET;
            ST_MANUAL: target = CNT_RESET;
        endcase
    end

    // An interval is over once the count reaches its programmed value.
    assign done = (cnt_q >= target);

    // Line-cycle interval counter, cleared on every state change.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= CNT_RESET;
        end else if (state_d != state_q) begin
            cnt_q <= CNT_RESET;
        end else if (tick && !done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Next state and chain request.
    always_comb begin
        state_d = state_q;
        chain_d = 1'b0;
        rep_d = rep_q;
        unique case (state_q)
            ST_IDLE: begin
                rep_d = 1'b0;
                if (manual_mode() && first_lvl) begin
                    state_d = ST_MANUAL;
                end else if (!manual_mode() && init) begin
                    if (i_sqz_delay != SQZ_DLY_OFF && !seam_sel()) begin
                        state_d = ST_SQZ_DLY;
                    end else begin
                        state_d = ST_SQUEEZE;
                    end
                end
            end
            ST_SQZ_DLY: begin
                if (beat_q && !init) begin
                    state_d = ST_HOLD;
                end else if (done) begin
                    state_d = ST_SQUEEZE;
                end
            end
            ST_SQUEEZE: begin
                if (beat_q && !init) begin
                    state_d = ST_HOLD;
                end else if (done) begin
                    state_d = ST_WELD;
                end
            end
            ST_WELD: begin
                if ((beat_q || (seam_q && !nonbeat_q)) && !init) begin
                    state_d = ST_HOLD;
                end else if (seam_q && !nonbeat_q && i_cool == 7'h00) begin
                    state_d = ST_WELD;
                end else if (done) begin
                    if (seam_q) begin
                        state_d = ST_COOL;
                    end else if (imp_q + 1'b1 >= i_impulses) begin
                        state_d = ST_HOLD;
                    end else begin
                        state_d = ST_COOL;
                    end
                end
            end
            ST_COOL: begin
                if ((beat_q || (seam_q && !nonbeat_q)) && !init) begin
                    state_d = ST_HOLD;
                end else if (done) begin
                    // Beat seam keeps cycling without a new squeeze.
                    if (nonbeat_q && imp_q >= i_impulses && i_chained) begin
                        chain_d = 1'b1;
                    end else if (nonbeat_q && imp_q >= i_impulses) begin
                        state_d = ST_HOLD;
                    end else begin
                        state_d = ST_WELD;
                    end
                end
            end
            ST_HOLD: begin
                if (done) begin
                    if (i_chained && !seam_q) begin
                        chain_d = 1'b1;
                        state_d = ST_SQUEEZE;
                    end else if (i_repeat && init && !seam_q) begin
                        state_d = ST_OFF;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_OFF: begin
                if (!init) begin
                    state_d = ST_IDLE;
                end else if (done) begin
                    rep_d = 1'b1;
                    state_d = ST_SQUEEZE;
                end
            end
            ST_MANUAL: begin
                if (!first_lvl) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    function automatic logic manual_mode();
        return i_beat_init == BEAT_SQZ_WELD && i_heat == MANUAL_MARK
            && i_impulses == MANUAL_MARK;
    endfunction : manual_mode

    function automatic logic seam_sel();
        return i_seam_sel != SEAM_SPOT;
    endfunction : seam_sel

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            rep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rep_q <= rep_d;
        end
    end

    // Modes are taken when a sequence starts, so only a return of the
    // seam selection to its spot code leaves seam operation.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            seam_q <= 1'b0;
            nonbeat_q <= 1'b0;
            beat_q <= 1'b0;
            manual_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            seam_q <= seam_sel();
            nonbeat_q <= i_seam_sel == SEAM_NONBEAT;
            beat_q <= i_beat_init == BEAT_SQZ_WELD;
            manual_q <= manual_mode();
        end
    end

    // Marks that the first schedule's squeeze has been run; no logic reads
    // the mark, and chained schedules do not consult it.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sqz_done_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            sqz_done_q <= 1'b0;
        end else if (state_q == ST_SQUEEZE && done) begin
            sqz_done_q <= 1'b1;
        end
    end

    // Impulse count; non-beat seam counts one per heat pair.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            imp_q <= CNT_RESET;
        end else if (state_q == ST_IDLE || state_q == ST_HOLD
                     || chain_d) begin
            imp_q <= CNT_RESET;
        end else if (state_q == ST_WELD && state_d == ST_COOL) begin
            imp_q <= imp_q + 1'b1;
        end
    end

    // In non-beat seam both heat phases fire, second at its own percent.
    always_comb begin
        unique case (state_q)
            ST_WELD: fire_d = !(beat_q && !init);
            ST_COOL: fire_d = nonbeat_q && !done;
            ST_MANUAL: fire_d = second_lvl && first_lvl;
            ST_IDLE: fire_d = 1'b0;
            ST_SQZ_DLY: fire_d = 1'b0;
            ST_SQUEEZE: fire_d = 1'b0;
            ST_HOLD: fire_d = 1'b0;
            ST_OFF: fire_d = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_fire <= 1'b0;
            o_fire_percent <= 7'h00;
        end else begin
            o_fire <= fire_d && (state_d == state_q);
            o_fire_percent <= (state_q == ST_COOL) ? i_percent2 : i_percent;
        end
    end

    // Valve stays on from squeeze delay through hold; electrodes open in
    // off so a repeat series can reposition between welds.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_valve <= 1'b0;
        end else begin
            o_valve <= state_d != ST_IDLE && state_d != ST_OFF;
        end
    end

    // Dimming is done by pulse-width on a free-running 3-bit count, which
    // is cheap and far above any visible flicker rate.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            dim_q <= 3'h0;
        end else begin
            dim_q <= dim_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sqz_led <= 1'b0;
            o_sqz_dim <= 1'b0;
        end else begin
            o_sqz_dim <= state_d == ST_SQZ_DLY;
            o_sqz_led <= state_d == ST_SQUEEZE
                || (state_d == ST_SQZ_DLY && dim_q < DIM_ON);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_next_sched <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_next_sched <= chain_d;
            o_busy <= state_d != ST_IDLE;
        end
    end

    // Tie off the squeeze-done mark, manual flag and repeat flag, which no
    // other logic reads; no chain path consults the squeeze-done mark.
    logic unused_ok;
    assign unused_ok = sqz_done_q | manual_q | rep_q;
endmodule : wst_sequencer
`default_nettype wire

// File: wst_seq_properties.sv
// Concurrent checks on the ports of the weld sequence timer.
// Assumes one clock domain and settings held steady while o_busy is high.
`timescale 1ns/10ps
`default_nettype none
module wst_seq_properties
    import wst_pkg::*;
#(
    parameter int unsigned P_LINE_DIV = LINE_DIV
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Settings
    input wire logic [7:0] i_seam_sel,
    input wire logic [7:0] i_sqz_delay,
    input wire logic [6:0] i_heat,
    input wire logic [6:0] i_impulses,
    input wire logic [6:0] i_percent,
    input wire logic [6:0] i_percent2,
    // Outputs watched
    input wire logic o_fire,
    input wire logic [6:0] o_fire_percent,
    input wire logic o_valve,
    input wire logic o_sqz_led,
    input wire logic o_sqz_dim,
    input wire logic o_next_sched,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // One line cycle of slack on each end of the longest heat.
    localparam logic [31:0] RUN_MAX = (32'(HEAT_MAX) + 2) * P_LINE_DIV;
    logic [31:0] run_q;
    logic manual;
    assign manual = (i_heat == MANUAL_MARK) && (i_impulses == MANUAL_MARK);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            run_q <= '0;
        end else if (o_fire) begin
            run_q <= run_q + 32'h1;
        end else begin
            run_q <= '0;
        end
    end

    property p_fire_valve;
        o_fire |-> o_valve && o_busy;
    endproperty
    a_fire_valve: assert property (p_fire_valve)
        else $error("current on without valve");
    property p_valve_first;
        $rose(o_fire) |-> $past(o_valve);
    endproperty
    a_valve_first: assert property (p_valve_first)
        else $error("current started without valve");
    property p_dim;
        o_sqz_dim |-> !o_fire && o_valve && o_busy;
    endproperty
    a_dim: assert property (p_dim)
        else $error("squeeze delay out of place");
    property p_idle;
        !o_busy |-> !o_fire && !o_valve && !o_sqz_led && !o_sqz_dim;
    endproperty
    a_idle: assert property (p_idle)
        else $error("output active while idle");
    property p_dly_off;
        (i_sqz_delay == SQZ_DLY_OFF) |-> !o_sqz_dim;
    endproperty
    a_dly_off: assert property (p_dly_off)
        else $error("delay shown while disabled");
    property p_nonbeat_pct;
        (i_seam_sel == SEAM_NONBEAT && o_fire)
            |-> (o_fire_percent == i_percent || o_fire_percent == i_percent2);
    endproperty
    a_nonbeat_pct: assert property (p_nonbeat_pct)
        else $error("non-beat current level wrong");
    property p_spot_pct;
        (i_seam_sel == SEAM_SPOT && o_fire) |-> o_fire_percent == i_percent;
    endproperty
    a_spot_pct: assert property (p_spot_pct)
        else $error("spot current level wrong");
    property p_no_chain;
        (i_seam_sel == SEAM_CONT) |-> !o_next_sched;
    endproperty
    a_no_chain: assert property (p_no_chain)
        else $error("chaining in beat seam");
    property p_next_pulse;
        o_next_sched |=> !o_next_sched;
    endproperty
    a_next_pulse: assert property (p_next_pulse)
        else $error("schedule advance longer than a pulse");
    property p_heat_cap;
        (i_seam_sel == SEAM_SPOT && !manual) |-> run_q <= RUN_MAX;
    endproperty
    a_heat_cap: assert property (p_heat_cap)
        else $error("heat beyond limit");

    c_dim: cover property (o_sqz_dim);
    c_pct2: cover property (o_fire && i_seam_sel == SEAM_NONBEAT
        && o_fire_percent == i_percent2);
    c_cut: cover property ($fell(o_fire) && o_valve);
endmodule : wst_seq_properties

bind wst_sequencer wst_seq_properties #(.P_LINE_DIV(P_LINE_DIV)) u_props (
    .i_clk, .i_reset, .i_seam_sel, .i_sqz_delay, .i_heat, .i_impulses,
    .i_percent, .i_percent2, .o_fire, .o_fire_percent, .o_valve,
    .o_sqz_led, .o_sqz_dim, .o_next_sched, .o_busy
);
`default_nettype wire

// File: wst_operator.sv
// Operator model: the two stage switches and the programmed settings.
// Assumes its tasks are called from one process; values move 1 ns past
// a rising edge.
`timescale 1ns/10ps
`default_nettype none
module wst_operator
    import wst_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Switches
    output logic o_first,
    output logic o_second,
    // Settings
    output logic [7:0] o_seam,
    output logic [7:0] o_beat,
    output logic [7:0] o_dly,
    output logic o_rep,
    // Schedule: squeeze, heat, percent, hold, off, impulses, cool, percent2
    output logic [6:0] o_sched [8]
);
    initial begin
        o_first = 1'b0;
        o_second = 1'b0;
        o_seam = SEAM_SPOT;
        o_beat = 8'h00;
        o_dly = SQZ_DLY_OFF;
        o_rep = 1'b0;
        o_sched = '{default: CNT_RESET};
    end

    task set_mode(input logic [7:0] s, b, d, input logic r);
        @(posedge i_clk);
        #1;
        o_seam = s;
        o_beat = b;
        o_dly = d;
        o_rep = r;
    endtask : set_mode

    task set_sched(input logic [6:0] sq, ht, pc, hd, of, im, cl, p2);
        @(posedge i_clk);
        #1;
        o_sched = '{sq, ht, pc, hd, of, im, cl, p2};
    endtask : set_sched

    // Switches move only between edges, as a contact bounce would not.
    task sw(input logic f, s);
        @(posedge i_clk);
        #1;
        o_first = f;
        o_second = s;
    endtask : sw
endmodule : wst_operator
`default_nettype wire

// File: wst_sequencer_bench.sv
// Self-checking bench for the weld sequence timer.
// Assumes a line cycle of four clocks, so intervals stay short.
`timescale 1ns/10ps
`default_nettype none
module wst_sequencer_bench
    import wst_pkg::*;
;
    logic i_clk, i_reset, first, second, rep, chain;
    logic [7:0] seam, beat, dly;
    logic [6:0] sch [8];
    logic o_fire, o_valve, o_sqz_led, o_sqz_dim, o_next_sched, o_busy;
    logic [6:0] o_fire_percent;
    int fail_count, tests_run, runs, run_now, last_run, fire_tot;
    int dim_cyc, pct2_cyc, sqz_cyc;

    wst_sequencer #(.P_LINE_DIV(4)) dut (
        .i_clk, .i_reset, .i_first_stage(first), .i_second_stage(second),
        .i_seam_sel(seam), .i_beat_init(beat), .i_sqz_delay(dly),
        .i_squeeze(sch[0]), .i_heat(sch[1]), .i_percent(sch[2]),
        .i_hold(sch[3]), .i_off(sch[4]), .i_impulses(sch[5]),
        .i_cool(sch[6]), .i_percent2(sch[7]), .i_chained(chain),
        .i_repeat(rep), .o_fire, .o_fire_percent, .o_valve, .o_sqz_led,
        .o_sqz_dim, .o_next_sched, .o_busy
    );
    wst_operator op (
        .i_clk, .o_first(first), .o_second(second), .o_seam(seam),
        .o_beat(beat), .o_dly(dly), .o_rep(rep), .o_sched(sch)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Current bursts are measured here so scenarios need not poll.
    always @(posedge i_clk) begin
        if (o_fire === 1'b1) begin
            run_now++;
            fire_tot++;
        end else if (run_now > 0) begin
            last_run = run_now;
            runs++;
            run_now = 0;
        end
        if (o_sqz_dim === 1'b1) dim_cyc++;
        if (o_sqz_led === 1'b1) sqz_cyc++;
        if (o_fire === 1'b1 && seam === SEAM_NONBEAT
            && o_fire_percent === sch[7]) pct2_cyc++;
    end

    task tally_and_finish;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task check(input string what, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic logic in_rng(input int v, lo, hi);
        return v >= lo && v <= hi;
    endfunction : in_rng

    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task clr;
        runs = 0;
        run_now = 0;
        last_run = 0;
        fire_tot = 0;
        dim_cyc = 0;
        pct2_cyc = 0;
        sqz_cyc = 0;
    endtask : clr

    task wait_runs(input int n);
        for (int k = 0; k < 2000 && runs < n; k++) cyc(1);
        check("fire bursts", 16'(runs), 16'(n));
    endtask : wait_runs

    task wait_fire;
        for (int k = 0; k < 500 && run_now == 0; k++) cyc(1);
        check("fire start", 16'(run_now > 0), 16'h1);
    endtask : wait_fire

    task wait_idle;
        for (int k = 0; k < 2000 && o_busy !== 1'b0; k++) cyc(1);
        check("busy", o_busy, 1'b0);
    endtask : wait_idle

    task t_spot;
        clr();
        op.set_mode(SEAM_SPOT, 8'h00, SQZ_DLY_OFF, 1'b0);
        op.set_sched(7'h02, 7'h03, 7'h28, 7'h02, 7'h00, 7'h01, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        cyc(8);
        check("valve", o_valve, 1'b1);
        check("fire early", o_fire, 1'b0);
        wait_fire();
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("heat span", in_rng(last_run, 8, 17), 1'b1);
        check("dim", 16'(dim_cyc), 16'h0);
        check("valve off", o_valve, 1'b0);
    endtask : t_spot

    task t_sqz_dly;
        clr();
        op.set_mode(SEAM_SPOT, 8'h00, 8'h03, 1'b1);
        op.set_sched(7'h02, 7'h02, 7'h28, 7'h01, 7'h02, 7'h01, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        cyc(8);
        check("dim", o_sqz_dim, 1'b1);
        check("fire in delay", o_fire, 1'b0);
        wait_runs(2);
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("delay once", in_rng(dim_cyc, 8, 17), 1'b1);
        op.set_sched(7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        cyc(8);
        check("dim empty", o_sqz_dim, 1'b1);
        op.sw(1'b0, 1'b0);
        wait_idle();
    endtask : t_sqz_dly

    task t_nonbeat;
        clr();
        op.set_mode(SEAM_NONBEAT, 8'h00, SQZ_DLY_OFF, 1'b0);
        op.set_sched(7'h01, 7'h02, 7'h32, 7'h01, 7'h00, 7'h03, 7'h02, 7'h1E);
        op.sw(1'b0, 1'b1);
        wait_runs(1);
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("heat total", in_rng(fire_tot, 36, 60), 1'b1);
        check("second heat", in_rng(pct2_cyc, 12, 36), 1'b1);
        clr();
        chain = 1'b1;
        op.sw(1'b0, 1'b1);
        for (int k = 0; k < 900 && o_next_sched !== 1'b1; k++) cyc(1);
        check("schedule advance", o_next_sched, 1'b1);
        chain = 1'b0;
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("chained heats", in_rng(fire_tot, 70, 100), 1'b1);
    endtask : t_nonbeat

    task t_seam;
        clr();
        op.set_mode(SEAM_CONT, 8'h00, SQZ_DLY_OFF, 1'b0);
        chain = 1'b1;
        op.set_sched(7'h01, 7'h01, 7'h28, 7'h01, 7'h00, 7'h01, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        wait_fire();
        cyc(100);
        check("fire held", o_fire, 1'b1);
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("fire off", o_fire, 1'b0);
        clr();
        op.set_sched(7'h01, 7'h01, 7'h28, 7'h01, 7'h00, 7'h01, 7'h02, 7'h00);
        op.sw(1'b0, 1'b1);
        wait_runs(3);
        check("squeeze once", in_rng(sqz_cyc, 2, 5), 1'b1);
        op.sw(1'b0, 1'b0);
        wait_idle();
        chain = 1'b0;
    endtask : t_seam

    task t_braze;
        clr();
        op.set_mode(SEAM_SPOT, BEAT_SQZ_WELD, SQZ_DLY_OFF, 1'b0);
        op.set_sched(7'h01, 7'h05, 7'h28, 7'h02, 7'h00, 7'h01, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        wait_runs(1);
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("full heat", in_rng(last_run, 16, 25), 1'b1);
        clr();
        op.set_sched(7'h05, 7'h14, 7'h28, 7'h03, 7'h00, 7'h01, 7'h00, 7'h00);
        op.sw(1'b0, 1'b1);
        cyc(7);
        op.sw(1'b0, 1'b0);
        wait_idle();
        check("open in squeeze", 16'(runs + run_now), 16'h0);
        op.sw(1'b0, 1'b1);
        wait_fire();
        cyc(10);
        op.sw(1'b0, 1'b0);
        cyc(7);
        check("cut fire", o_fire, 1'b0);
        check("hold valve", o_valve, 1'b1);
        wait_idle();
        check("valve released", o_valve, 1'b0);
    endtask : t_braze

    task t_manual;
        clr();
        op.set_mode(SEAM_SPOT, BEAT_SQZ_WELD, SQZ_DLY_OFF, 1'b0);
        op.set_sched(7'h00, 7'h63, 7'h3C, 7'h00, 7'h00, 7'h63, 7'h00, 7'h00);
        op.sw(1'b1, 1'b0);
        cyc(8);
        check("closed", o_valve, 1'b1);
        check("no current", o_fire, 1'b0);
        for (int i = 0; i < 2; i++) begin
            op.sw(1'b1, 1'b1);
            cyc(8);
            check("current", o_fire, 1'b1);
            check("level", o_fire_percent, 7'h3C);
            op.sw(1'b1, 1'b0);
            cyc(8);
            check("current stop", o_fire, 1'b0);
            check("stay closed", o_valve, 1'b1);
        end
        op.sw(1'b0, 1'b0);
        cyc(8);
        check("retract", o_valve, 1'b0);
        wait_idle();
    endtask : t_manual

    initial begin
        fail_count = 0;
        tests_run = 0;
        chain = 1'b0;
        clr();
        i_reset = 1'b1;
        repeat (10) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        cyc(2);
        t_spot();
        t_sqz_dly();
        t_nonbeat();
        t_seam();
        t_braze();
        t_manual();
        tally_and_finish();
    end

    // The scenarios take about 1000 clocks; this allows ten times that.
    initial begin
        #400000;
        fail_count++;
        $display("ERROR watchdog expected done seen running");
        tally_and_finish();
    end
endmodule : wst_sequencer_bench
`default_nettype wire
